// *** pmt_pkg.sv ***
// Constants shared by the motion trigger control block
`default_nettype none
package pmt_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Base time step: every long interval is counted in ticks of this size
    localparam int TICK_MS = 50;
    localparam int TICK_CYCLES_DEF = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int WARM_MS = 12000;
    localparam logic [7:0] WARM_TICKS = 8'(WARM_MS / TICK_MS);
    // Blink rates in millihertz; half period in ticks
    localparam int BLINK_WARM_MHZ = 2500;
    localparam int BLINK_DET_MHZ = 250;
    localparam int BLINK_LOWV_MHZ = 2000;
    localparam logic [7:0] HALF_WARM = 8'(500000 / (BLINK_WARM_MHZ * TICK_MS));
    localparam logic [7:0] HALF_DET = 8'(500000 / (BLINK_DET_MHZ * TICK_MS));
    localparam logic [7:0] HALF_LOWV = 8'(500000 / (BLINK_LOWV_MHZ * TICK_MS));
    // Stand-alone pulse lengths, one per resistance step
    localparam logic [17:0] SA_T0 = 18'(3000 / TICK_MS);
    localparam logic [17:0] SA_T1 = 18'(10000 / TICK_MS);
    localparam logic [17:0] SA_T2 = 18'(38000 / TICK_MS);
    localparam logic [17:0] SA_T3 = 18'(60000 / TICK_MS);
    localparam logic [17:0] SA_T4 = 18'(180000 / TICK_MS);
    localparam logic [17:0] SA_T5 = 18'(300000 / TICK_MS);
    localparam logic [17:0] SA_T6 = 18'(600000 / TICK_MS);
    localparam int HOST_UNIT_MS = 100;
    localparam int ACT_MS = 30000;
    localparam logic [1:0] HOST_TICKS = 2'(HOST_UNIT_MS / TICK_MS);
    localparam logic [15:0] TIME_RESET = 16'(ACT_MS / HOST_UNIT_MS);
    // Target address is arbitrary
    localparam logic [6:0] TARGET_ADDR_DEF = 7'h4C;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_THRESH = 8'h01;
    localparam logic [7:0] REG_GAIN = 8'h02;
    localparam logic [7:0] REG_TIME_HI = 8'h03;
    localparam logic [7:0] REG_TIME_LO = 8'h04;
    localparam logic [7:0] REG_LVD = 8'h05;
    localparam logic [7:0] REG_TMODE = 8'h06;
    localparam logic [2:0] THRESH_RESET = 3'h3;
    localparam logic [4:0] GAIN_RESET = 5'h0F;
    localparam logic [2:0] LVD_RESET = 3'h0;
    typedef enum logic [2:0] {
        ST_STRAP = 3'b001,
        ST_WARM = 3'b010,
        ST_DETECT = 3'b100
    } pmt_state_e;
endpackage
`default_nettype wire

// *** pmt_control.sv ***
// Motion trigger control: mode strap, pulse timing, status blink, I2C target
// What this block does
// - Mode taken from strap level: low stand-alone
// - Stand-alone detection gives one trigger pulse
// - Stand-alone pulse length from resistance step
// - Networked detection gives activity pulse of host time, thirty seconds at reset
// - Host configures and reads over I2C target
// - Status pin: LED stand-alone, data line networked
// - Warm-up blinks indicator at 2.5 Hz
// - Detection state blinks indicator at 0.25 Hz
// - Supply below 2.7 V blinks at 2 Hz
// - Trigger only while light input above threshold
// - No photo sensor fitted keeps triggering enabled
// - Host sets eight thresholds, thirty-two gains
// - Host time is 16-bit count of 100 ms
// - Host picks one of eight low-voltage thresholds
// - Warm-up lasts at most twelve seconds
// - Host selects single or continuous triggering
`default_nettype none
module pmt_control
    import pmt_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEF
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic motionDetect,
    input wire logic lightSenseFitted,
    input wire logic lightSenseAbove,
    input wire logic lowSupply,
    input wire logic [7:0] lvdBelow,
    input wire logic [2:0] durationStep,
    input wire logic modeStrapIn,
    input wire logic sdaIn,
    input wire logic sclIn,
    output logic statusOut,
    output logic statusOe,
    output logic triggerOut,
    output logic triggerOe,
    output logic activityOut,
    output logic activityOe,
    output logic [2:0] thresholdSel,
    output logic [4:0] gainSel,
    output logic networked
);
    pmt_state_e state;
    logic netMode;
    logic [31:0] tickCnt;
    logic [7:0] warmCnt;
    logic [7:0] blinkCnt;
    logic led;
    logic [17:0] pulseCnt;
    logic pulseOn;
    logic [15:0] regTime;
    logic [2:0] regLvd;
    logic regCont;
    logic sclPrev, sdaPrev, addressed, rw, ackPhase, sdaLow;
    logic [3:0] bitCnt;
    logic [1:0] byteIdx;
    logic [7:0] rxByte, txByte, ptr;
    logic [17:0] saLen;
    logic [7:0] rdData;

    wire tick = tickCnt == 32'(TICK_CYCLES - 1);
    wire running = state != ST_STRAP;
    // Networked low-voltage uses the host-chosen comparator tap
    wire lowVolt = netMode ? lvdBelow[regLvd] : lowSupply;
    wire lightEnable = !lightSenseFitted || lightSenseAbove;
    wire detectOk = state == ST_DETECT && motionDetect && lightEnable;
    wire contMode = netMode && regCont;
    wire [17:0] pulseLen = netMode ? 18'(regTime * HOST_TICKS) : saLen;
    // Single mode ignores detections while a pulse runs; continuous restarts it
    wire startPulse = detectOk && (!pulseOn || contMode);
    wire [7:0] blinkHalf = lowVolt ? HALF_LOWV :
        (state == ST_WARM ? HALF_WARM : HALF_DET);
    wire i2cOn = netMode && running;
    wire sclRise = sclIn && !sclPrev;
    wire sclFall = !sclIn && sclPrev;
    wire startCond = sclIn && sclPrev && sdaPrev && !sdaIn;
    wire stopCond = sclIn && sclPrev && !sdaPrev && sdaIn;
    wire byteDone = sclFall && !ackPhase && bitCnt == 4'h8;
    wire addrMatch = rxByte[7:1] == TARGET_ADDR;
    wire regWrite = byteDone && addressed && !rw && byteIdx == 2'h2;

    always_comb begin
        case (durationStep)
            3'h0: saLen = SA_T0;
            3'h1: saLen = SA_T1;
            3'h2: saLen = SA_T2;
            3'h3: saLen = SA_T3;
            3'h4: saLen = SA_T4;
            3'h5: saLen = SA_T5;
            default: saLen = SA_T6;
        endcase
    end

    always_comb begin
        case (ptr)
            REG_STATUS: rdData = {5'h00, lowVolt, pulseOn, state == ST_WARM};
            REG_THRESH: rdData = {5'h00, thresholdSel};
            REG_GAIN: rdData = {3'h0, gainSel};
            REG_TIME_HI: rdData = regTime[15:8];
            REG_TIME_LO: rdData = regTime[7:0];
            REG_LVD: rdData = {5'h00, regLvd};
            REG_TMODE: rdData = {7'h00, regCont};
            default: rdData = 8'h00;
        endcase
    end

    // Strap is caught on the first clock after reset release, then held
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= ST_STRAP;
            netMode <= 1'b0;
            warmCnt <= 8'h00;
        end else begin
            case (state)
                ST_STRAP: begin
                    netMode <= modeStrapIn;
                    state <= ST_WARM;
                end
                ST_WARM: begin
                    if (tick) begin
                        warmCnt <= warmCnt + 8'h01;
                        if (warmCnt == WARM_TICKS - 8'h01) begin
                            state <= ST_DETECT;
                        end
                    end
                end
                ST_DETECT: state <= ST_DETECT;
                default: state <= ST_STRAP;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || tick) begin
            tickCnt <= 32'h00000000;
        end else begin
            tickCnt <= tickCnt + 32'h00000001;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || !running) begin
            blinkCnt <= 8'h00;
            led <= 1'b0;
        end else if (tick) begin
            if (blinkCnt >= blinkHalf - 8'h01) begin
                blinkCnt <= 8'h00;
                led <= !led;
            end else begin
                blinkCnt <= blinkCnt + 8'h01;
            end
        end
    end

    // Pulse length is quantised to the tick, so it may run short by one tick
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pulseCnt <= 18'h00000;
            pulseOn <= 1'b0;
        end else if (startPulse) begin
            pulseCnt <= pulseLen;
            pulseOn <= pulseLen != 18'h00000;
        end else if (tick && pulseOn) begin
            pulseCnt <= pulseCnt - 18'h00001;
            if (pulseCnt == 18'h00001) begin
                pulseOn <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            thresholdSel <= THRESH_RESET;
            gainSel <= GAIN_RESET;
            regTime <= TIME_RESET;
            regLvd <= LVD_RESET;
            regCont <= 1'b0;
        end else if (regWrite) begin
            case (ptr)
                REG_THRESH: thresholdSel <= rxByte[2:0];
                REG_GAIN: gainSel <= rxByte[4:0];
                REG_TIME_HI: regTime[15:8] <= rxByte;
                REG_TIME_LO: regTime[7:0] <= rxByte;
                REG_LVD: regLvd <= rxByte[2:0];
                REG_TMODE: regCont <= rxByte[0];
                default: regCont <= regCont;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sclIn;
            sdaPrev <= sdaIn;
        end
    end

    // Byte 0 address, byte 1 pointer, later bytes data with auto-increment
    always_ff @(posedge clock) begin
        if (!rstn || !i2cOn || startCond || stopCond) begin
            bitCnt <= 4'h0;
            byteIdx <= 2'h0;
            addressed <= 1'b0;
            rw <= 1'b0;
            ackPhase <= 1'b0;
            sdaLow <= 1'b0;
            rxByte <= 8'h00;
            txByte <= 8'h00;
            if (!rstn) begin
                ptr <= 8'h00;
            end
        end else if (sclRise) begin
            if (ackPhase) begin
                if (rw && sdaIn) begin
                    addressed <= 1'b0;
                end
            end else begin
                rxByte <= {rxByte[6:0], sdaIn};
                bitCnt <= bitCnt + 4'h1;
            end
        end else if (sclFall) begin
            if (ackPhase) begin
                ackPhase <= 1'b0;
                bitCnt <= 4'h0;
                if (addressed && rw) begin
                    txByte <= rdData;
                    sdaLow <= !rdData[7];
                    ptr <= ptr + 8'h01;
                end else begin
                    sdaLow <= 1'b0;
                end
            end else if (byteDone) begin
                ackPhase <= 1'b1;
                if (byteIdx != 2'h2) begin
                    byteIdx <= byteIdx + 2'h1;
                end
                if (byteIdx == 2'h0) begin
                    addressed <= addrMatch;
                    rw <= rxByte[0];
                    sdaLow <= addrMatch;
                end else if (addressed && !rw) begin
                    sdaLow <= 1'b1;
                    if (byteIdx == 2'h1) begin
                        ptr <= rxByte;
                    end else begin
                        ptr <= ptr + 8'h01;
                    end
                end else begin
                    sdaLow <= 1'b0;
                end
            end else if (addressed && rw && bitCnt != 4'h0) begin
                sdaLow <= !txByte[3'(4'h7 - bitCnt)];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            statusOut <= 1'b0;
            statusOe <= 1'b0;
            triggerOut <= 1'b0;
            triggerOe <= 1'b0;
            activityOut <= 1'b0;
            activityOe <= 1'b0;
            networked <= 1'b0;
        end else begin
            statusOut <= !netMode && led;
            statusOe <= running && (netMode ? sdaLow : 1'b1);
            triggerOut <= !netMode && pulseOn;
            triggerOe <= running && !netMode;
            activityOut <= netMode && pulseOn;
            activityOe <= running && netMode;
            networked <= netMode;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_sa_detect;
        detectOk && !netMode && !pulseOn;
    endsequence
    sequence s_sa_pulse;
        pulseOn ##1 triggerOut;
    endsequence
    sequence s_net_detect;
        detectOk && netMode && !pulseOn && regTime != 16'h0000;
    endsequence

    property p_strap_take;
        state == ST_STRAP |=> netMode == $past(modeStrapIn);
    endproperty
    a_strap_take: assert property (p_strap_take) else $error("mode not from strap");
    property p_mode_hold;
        running |=> $stable(netMode) && running;
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
    property p_sa_pulse;
        s_sa_detect |=> s_sa_pulse;
    endproperty
    a_sa_pulse: assert property (p_sa_pulse) else $error("no trigger pulse");
    property p_len;
        startPulse |=> pulseCnt == $past(pulseLen);
    endproperty
    a_len: assert property (p_len) else $error("pulse length wrong");
    property p_net_pulse;
        s_net_detect |=> pulseOn ##1 activityOut && !triggerOut;
    endproperty
    a_net_pulse: assert property (p_net_pulse) else $error("no activity pulse");
    property p_light;
        !lightEnable && !pulseOn |=> !pulseOn;
    endproperty
    a_light: assert property (p_light) else $error("pulse while dark");
    property p_single;
        pulseOn && !contMode && detectOk && !tick |=> $stable(pulseCnt);
    endproperty
    a_single: assert property (p_single) else $error("single mode retriggered");
    property p_warm_end;
        state == ST_WARM && tick && warmCnt == WARM_TICKS - 8'h01 |=> state == ST_DETECT;
    endproperty
    a_warm_end: assert property (p_warm_end) else $error("warm-up overran");
    property p_lowv_prio;
        lowVolt && tick && running && blinkCnt == HALF_LOWV - 8'h01 |=> led != $past(led);
    endproperty
    a_lowv_prio: assert property (p_lowv_prio) else $error("low-voltage blink lost");
    property p_sa_status;
        running && !netMode |=> statusOe;
    endproperty
    a_sa_status: assert property (p_sa_status) else $error("LED pin not driven");
endmodule
`default_nettype wire

// *** pmt_i2c_host.sv ***
// I2C host model that reads and configures the module over the shared pins
`default_nettype none
module pmt_i2c_host (
    input wire logic clock,
    input wire logic sdaLine,
    output logic sdaLow,
    output logic sclLow
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sdaLow = 1'b0;
        sclLow = 1'b0;
    end
    // Eight clocks per half bit keeps well above the target's minimum of four
    task automatic halfBit();
        repeat (8) @(posedge clock);
    endtask
    // Works from idle and as a repeated start after an acknowledge
    task automatic startCond();
        sdaLow <= 1'b0;
        halfBit();
        sclLow <= 1'b0;
        halfBit();
        sdaLow <= 1'b1;
        halfBit();
        sclLow <= 1'b1;
        halfBit();
    endtask
    task automatic stopCond();
        sdaLow <= 1'b1;
        halfBit();
        sclLow <= 1'b0;
        halfBit();
        sdaLow <= 1'b0;
        halfBit();
    endtask
    task automatic putBit(input logic b);
        sdaLow <= ~b;
        halfBit();
        sclLow <= 1'b0;
        halfBit();
        sclLow <= 1'b1;
        halfBit();
    endtask
    task automatic getBit(output logic b);
        sdaLow <= 1'b0;
        halfBit();
        sclLow <= 1'b0;
        halfBit();
        b = sdaLine;
        sclLow <= 1'b1;
        halfBit();
    endtask
    task automatic putByte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) putBit(v[i]);
        getBit(b);
        ack = ~b;
    endtask
    task automatic writeReg(input logic [6:0] addr, input logic [7:0] ptr,
                            input logic [7:0] v, output logic ok);
        logic a0, a1, a2;
        startCond();
        putByte({addr, 1'b0}, a0);
        putByte(ptr, a1);
        putByte(v, a2);
        stopCond();
        ok = a0 & a1 & a2;
    endtask
    task automatic readReg(input logic [6:0] addr, input logic [7:0] ptr,
                           output logic [7:0] v, output logic ok);
        logic a0, a1, a2;
        startCond();
        putByte({addr, 1'b0}, a0);
        putByte(ptr, a1);
        startCond();
        putByte({addr, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) getBit(v[i]);
        putBit(1'b1);
        stopCond();
        ok = a0 & a1 & a2;
    endtask
endmodule
`default_nettype wire

// *** tb_pir_motion_trigger_control.sv ***
// Self-checking bench for the motion trigger control block
`default_nettype none
module tb_pir_motion_trigger_control import pmt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // Short tick keeps the longest pulse tested, step 4, inside the 40000-cycle limit
    localparam int T = 10;
    typedef struct {
        logic [2:0] step;
        logic fitted;
        logic above;
        int again;
        int ticks;
    } pmt_row_s;
    pmt_row_s rows [7];
    logic clock = 1'b0, rstn = 1'b0, motionDetect = 1'b0, lightSenseFitted = 1'b0;
    logic lightSenseAbove = 1'b0, lowSupply = 1'b0, modeStrapIn = 1'b0;
    logic [7:0] lvdBelow = 8'h00;
    logic [2:0] durationStep = 3'h0;
    logic statusOut, statusOe, triggerOut, triggerOe, activityOut, activityOe, networked;
    logic sdaLow, sclLow;
    logic [2:0] thresholdSel;
    logic [4:0] gainSel;
    int err_count = 0, checks = 0;
    wire logic sdaLine = (sdaLow | (statusOe & ~statusOut)) ? 1'b0 : 1'b1;
    wire logic sclLine = (sclLow | (triggerOe & ~triggerOut)) ? 1'b0 : 1'b1;
    wire logic anyPulse = triggerOut | activityOut;
    pmt_control #(.TICK_CYCLES(T)) DUT (.clock(clock), .rstn(rstn),
        .motionDetect(motionDetect), .lightSenseFitted(lightSenseFitted),
        .lightSenseAbove(lightSenseAbove), .lowSupply(lowSupply), .lvdBelow(lvdBelow),
        .durationStep(durationStep), .modeStrapIn(modeStrapIn), .sdaIn(sdaLine),
        .sclIn(sclLine), .statusOut(statusOut), .statusOe(statusOe),
        .triggerOut(triggerOut), .triggerOe(triggerOe), .activityOut(activityOut),
        .activityOe(activityOe), .thresholdSel(thresholdSel), .gainSel(gainSel),
        .networked(networked));
    pmt_i2c_host host (.clock(clock), .sdaLine(sdaLine), .sdaLow(sdaLow), .sclLow(sclLow));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic doReset(input logic strap);
        @(posedge clock);
        modeStrapIn <= strap;
        rstn <= 1'b0;
        repeat (5) @(posedge clock);
        @(negedge clock);
        chk({statusOut, statusOe, triggerOut, triggerOe, activityOut, activityOe} === 6'h00
            && networked === 1'b0 && thresholdSel === THRESH_RESET && gainSel === GAIN_RESET,
            "reset");
        @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(negedge clock);
        chk(networked === strap && triggerOe === ~strap && activityOe === strap
            && statusOe === ~strap, "mode");
        @(posedge clock);
        modeStrapIn <= ~strap;
        repeat (3) @(negedge clock);
        chk(networked === strap, "strap resampled");
        $display("reset test done");
    endtask
    task automatic pulseLen(input int again, output int n);
        n = -1;
        @(posedge clock);
        motionDetect <= 1'b1;
        @(posedge clock);
        motionDetect <= 1'b0;
        if (again > 0) begin
            fork
                begin
                    repeat (again - 1) @(posedge clock);
                    motionDetect <= 1'b1;
                    @(posedge clock);
                    motionDetect <= 1'b0;
                end
            join_none
        end
        for (int i = 0; i < 6 && n < 0; i++) begin
            @(negedge clock);
            if (anyPulse === 1'b1) n = 0;
        end
        while (n >= 0 && anyPulse === 1'b1 && n < 40000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 40000) begin
            chk(1'b0, "pulse never ends");
            give_verdict();
        end
    endtask
    // The tick phase runs free, so a pulse may come up to one tick short
    task automatic expectLen(input int n, input int ticks, input string msg);
        if (ticks == 0) chk(n == -1, msg);
        else chk(n > (ticks - 1) * T - 3 && n <= ticks * T + 2, msg);
    endtask
    task automatic halfPeriod(output int n);
        logic last;
        for (int k = 0; k < 3; k++) begin
            @(negedge clock);
            last = statusOut;
            n = 0;
            while (statusOut === last && n < 2000) begin
                @(negedge clock);
                n++;
            end
        end
        n++;
        if (n > 2000) begin
            chk(1'b0, "blink stuck");
            give_verdict();
        end
    endtask
    initial begin
        rows = '{'{3'h0, 1'b0, 1'b0, 0, SA_T0}, '{3'h0, 1'b1, 1'b1, 20 * T, SA_T0},
            '{3'h1, 1'b1, 1'b0, 0, 0}, '{3'h1, 1'b0, 1'b1, 0, SA_T1},
            '{3'h2, 1'b0, 1'b0, 0, SA_T2}, '{3'h4, 1'b0, 1'b0, 0, SA_T4},
            '{3'h3, 1'b0, 1'b0, 0, SA_T3}};
    end
    initial begin
        int n;
        logic [7:0] v;
        logic ok;
        doReset(1'b0);
        pulseLen(0, n);
        expectLen(n, 0, "detection during warm-up");
        halfPeriod(n);
        chk(n === HALF_WARM * T, "warm-up blink");
        repeat (WARM_TICKS * T) @(posedge clock);
        halfPeriod(n);
        chk(n === HALF_DET * T, "detection blink");
        @(posedge clock);
        lowSupply <= 1'b1;
        halfPeriod(n);
        chk(n === HALF_LOWV * T, "low supply blink");
        @(posedge clock);
        lowSupply <= 1'b0;
        $display("blink test done");
        foreach (rows[r]) begin
            @(posedge clock);
            durationStep <= rows[r].step;
            lightSenseFitted <= rows[r].fitted;
            lightSenseAbove <= rows[r].above;
            pulseLen(rows[r].again, n);
            expectLen(n, rows[r].ticks, "trigger pulse");
            $display("row %0d done", r);
        end
        doReset(1'b1);
        host.readReg(TARGET_ADDR_DEF, REG_STATUS, v, ok);
        chk(ok === 1'b1 && v[0] === 1'b1 && statusOut === 1'b0, "warm-up status");
        host.writeReg(TARGET_ADDR_DEF ^ 7'h01, REG_THRESH, 8'h05, ok);
        chk(ok === 1'b0 && thresholdSel === THRESH_RESET, "foreign address");
        host.writeReg(TARGET_ADDR_DEF, REG_THRESH, 8'h05, ok);
        host.writeReg(TARGET_ADDR_DEF, REG_GAIN, 8'h1A, ok);
        chk(ok === 1'b1 && thresholdSel === 3'h5 && gainSel === 5'h1A, "sensitivity");
        host.readReg(TARGET_ADDR_DEF, REG_GAIN, v, ok);
        chk(ok === 1'b1 && v === 8'h1A, "gain readback");
        host.writeReg(TARGET_ADDR_DEF, REG_LVD, 8'h02, ok);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            lvdBelow <= 8'h04 >> k;
            host.readReg(TARGET_ADDR_DEF, REG_STATUS, v, ok);
            chk(v[2] === (k == 0), "low-voltage select");
        end
        $display("host link test done");
        repeat (WARM_TICKS * T) @(posedge clock);
        pulseLen(0, n);
        expectLen(n, TIME_RESET * HOST_TICKS, "activity pulse");
        host.writeReg(TARGET_ADDR_DEF, REG_TIME_HI, 8'h00, ok);
        host.writeReg(TARGET_ADDR_DEF, REG_TIME_LO, 8'h03, ok);
        pulseLen(0, n);
        expectLen(n, 3 * HOST_TICKS, "host pulse time");
        host.writeReg(TARGET_ADDR_DEF, REG_TMODE, 8'h01, ok);
        pulseLen(4 * T, n);
        expectLen(n - 4 * T, 3 * HOST_TICKS, "continuous retrigger");
        $display("networked pulse test done");
        give_verdict();
    end
endmodule
`default_nettype wire
